// ==== core/hccd_top.v ====
// hdlc channel configuration descriptor bank with ahb-lite access and engine lookup
// Overview of operation
// - one word per channel and direction
// - pad adjust set reduces count on insertions
// - bits 29:24 give fifo start location
// - bits 21:16 allocate 2 x (len+1) words
// - bit 23 clear passes data uninverted
// - transmit bit 15 enables end-of-padfill interrupt
// - bits 14:12 select protocol, 4-7 reserved
// - length select zero disables length check
// - receive select 1/2 picks limit one/two
// - fcs bit clear: no store, append fcs
// - fcs bit set: store fcs, no append
// - no-fcs mode disables short-message detection
// - ss7 receive, mask clear: error-count interrupt
`timescale 1ns/100ps
`include "hccd_defs.vh"
module hccd_top (
  // clock and reset
  input  wire                     hclk,
  input  wire                     hresetn,
  // ahb-lite slave
  input  wire                     hsel,
  input  wire [31:0]              haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [31:0]              hwdata,
  input  wire                     hready,
  output reg  [31:0]              hrdata,
  output reg                      hreadyout,
  output reg                      hresp,
  // engine lookup request
  input  wire                     eng_req,
  input  wire                     eng_dir,
  input  wire [`HCCD_CHAN_W-1:0]  eng_chan,
  input  wire [`HCCD_LIMIT_W-1:0] length_limit_one,
  input  wire [`HCCD_LIMIT_W-1:0] length_limit_two,
  input  wire [7:0]               pad_fill_count,
  input  wire [7:0]               zero_insert_count,
  input  wire [7:0]               eng_data,
  // engine lookup answer
  output reg                      cfg_valid,
  output reg  [5:0]               cfg_fifo_start,
  output reg  [7:0]               cfg_fifo_words,
  output reg  [7:0]               cfg_data,
  output reg  [2:0]               cfg_protocol,
  output reg                      cfg_proto_reserved,
  output reg                      cfg_fcs_append,
  output reg                      cfg_fcs_store,
  output reg                      cfg_short_check,
  output reg                      cfg_len_check,
  output reg  [`HCCD_LIMIT_W-1:0] cfg_len_limit,
  output reg  [7:0]               cfg_pad_fill_count,
  // channel events
  input  wire                     padfill_done,
  input  wire [`HCCD_CHAN_W-1:0]  padfill_chan,
  input  wire                     signal_unit_error_event,
  input  wire [`HCCD_CHAN_W-1:0]  signal_unit_error_chan,
  // interrupt
  output reg                      irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // direction is the top index bit: one array half each
  function [`HCCD_IDX_W-1:0] cfg_index;
    input                    dir;
    input [`HCCD_CHAN_W-1:0] chan;
    begin
      cfg_index = {dir, chan};
    end
  endfunction

  // true inside the descriptor window only
  function is_cfg_addr;
    input [`HCCD_ADDR_W-1:0] a;
    begin
      is_cfg_addr = (a >= `HCCD_CFG_BASE) && (a <= `HCCD_CFG_LAST);
    end
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // receive words at indices 0-31, transmit at 32-63
  reg [31:0]              cfg_mem [0:`HCCD_NUM_WORDS-1];
  reg [`HCCD_IRQ_W-1:0]   irq_status;
  reg [`HCCD_IRQ_W-1:0]   irq_enable;

  // ----------------------------------------------------------------
  // ahb-lite address and data phase
  // ----------------------------------------------------------------
  reg                     dp_write;
  reg [`HCCD_ADDR_W-1:0]  dp_addr;
  reg                     dp_in_range;
  wire                    ap_valid;
  wire                    ap_in_range;
  wire [`HCCD_ADDR_W-1:0] ap_addr;
  wire [`HCCD_IDX_W-1:0]  ap_index;
  wire [`HCCD_IDX_W-1:0]  dp_index;
  wire                    dp_cfg_wr;
  wire                    clr_wr;
  wire                    en_wr;
  reg  [31:0]             next_hrdata;

  // idle and busy transfers are ignored
  assign ap_valid  = hsel && hready &&
                     ((htrans == `HCCD_HTRANS_NONSEQ) || (htrans == `HCCD_HTRANS_SEQ));
  assign ap_addr   = {haddr[`HCCD_ADDR_W-1:2], 2'b00};
  assign ap_index  = ap_addr[`HCCD_IDX_W+1:2];
  assign dp_index  = dp_addr[`HCCD_IDX_W+1:2];

  // haddr already belongs to the next transfer in the data phase,
  // so the upper bits are judged in the address phase
  assign ap_in_range = (haddr[31:`HCCD_ADDR_W] == 20'h00000);
  assign dp_cfg_wr = dp_write && dp_in_range && is_cfg_addr(dp_addr);
  assign clr_wr    = dp_write && dp_in_range && (dp_addr == `HCCD_IRQ_CLEAR);
  assign en_wr     = dp_write && dp_in_range && (dp_addr == `HCCD_IRQ_ENABLE);

  // a read right behind a write to the same word sees the new data
  // clear and unmapped words read as zero
  always @* begin
    next_hrdata = 32'h0000_0000;
    if (is_cfg_addr(ap_addr)) begin
      if (dp_cfg_wr && (dp_index == ap_index)) begin
        next_hrdata = hwdata;
      end else begin
        next_hrdata = cfg_mem[ap_index];
      end
    end else if (ap_addr == `HCCD_IRQ_STATUS) begin
      next_hrdata = {{(32-`HCCD_IRQ_W){1'b0}}, irq_status};
    end else if (ap_addr == `HCCD_IRQ_ENABLE) begin
      // an enable word still in its data phase is forwarded too
      if (en_wr) begin
        next_hrdata = {{(32-`HCCD_IRQ_W){1'b0}}, hwdata[`HCCD_IRQ_W-1:0]};
      end else begin
        next_hrdata = {{(32-`HCCD_IRQ_W){1'b0}}, irq_enable};
      end
    end
  end

  // upper address bits are caught with the word so aliases are not written
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write    <= 1'b0;
      dp_addr     <= {`HCCD_ADDR_W{1'b0}};
      dp_in_range <= 1'b0;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      // zero wait states and an okay answer for every access
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_write  <= ap_valid && hwrite;
      if (ap_valid) begin
        dp_addr     <= ap_addr;
        dp_in_range <= ap_in_range;
      end
      // hrdata stands until the next accepted read
      if (ap_valid && !hwrite) begin
        if (ap_in_range) begin
          hrdata <= next_hrdata;
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // descriptor writes
  // ----------------------------------------------------------------
  // reserved bits are stored as written; keeping them zero is software's job
  // hsize is not decoded: every write stores the full word
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // every channel starts transparent with all options off
      for (i = 0; i < `HCCD_NUM_WORDS; i = i + 1)
        cfg_mem[i] <= `HCCD_CFG_RESET;
    end else if (dp_cfg_wr) begin
      cfg_mem[dp_index] <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // channel events and interrupt
  // ----------------------------------------------------------------
  wire [31:0]            eop_word;
  wire [31:0]            su_word;
  wire [`HCCD_IRQ_W-1:0] evt_set;
  wire [`HCCD_IRQ_W-1:0] evt_clr;
  wire [`HCCD_IRQ_W-1:0] next_status;
  wire [`HCCD_IRQ_W-1:0] next_enable;

  // events read their own channel's word, apart from the engine port
  assign eop_word = cfg_mem[cfg_index(`HCCD_DIR_TX, padfill_chan)];
  assign su_word  = cfg_mem[cfg_index(`HCCD_DIR_RX, signal_unit_error_chan)];

  assign evt_set[`HCCD_IRQ_EOP]    = padfill_done && eop_word[`HCCD_EOP_IRQ_BIT];
  assign evt_set[`HCCD_IRQ_SU_ERR] = signal_unit_error_event && ~su_word[`HCCD_SUMSK_BIT] &&
                                     (su_word[`HCCD_PROTO_MSB:`HCCD_PROTO_LSB] == `HCCD_PROTO_SS7);
  assign evt_clr = clr_wr ? hwdata[`HCCD_IRQ_W-1:0] : {`HCCD_IRQ_W{1'b0}};

  // a new event in the clearing cycle keeps its bit set
  assign next_status = (irq_status & ~evt_clr) | evt_set;
  assign next_enable = en_wr ? hwdata[`HCCD_IRQ_W-1:0] : irq_enable;

  // irq uses the values being loaded, so it moves on the same edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= {`HCCD_IRQ_W{1'b0}};
      irq_enable <= {`HCCD_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq_enable <= next_enable;
      irq        <= |(next_status & next_enable);
    end
  end

  // ----------------------------------------------------------------
  // engine lookup
  // ----------------------------------------------------------------
  wire [31:0]              lk_word;
  wire [5:0]               d_fifo_start;
  wire [7:0]               d_fifo_words;
  wire [7:0]               d_data;
  wire [2:0]               d_protocol;
  wire                     d_proto_reserved;
  wire                     d_fcs_append;
  wire                     d_fcs_store;
  wire                     d_short_check;
  wire                     d_len_check;
  wire [`HCCD_LIMIT_W-1:0] d_len_limit;
  wire [7:0]               d_pad_fill;

  // rx and tx words of one channel are separate entries
  assign lk_word = cfg_mem[cfg_index(eng_dir, eng_chan)];

  // one decoder serves the engine port; events read raw bits
  hccd_cfg_decode u_decode (
    .cfg_word          (lk_word),
    .dir               (eng_dir),
    .length_limit_one  (length_limit_one),
    .length_limit_two  (length_limit_two),
    .pad_fill_count    (pad_fill_count),
    .zero_insert_count (zero_insert_count),
    .data_in           (eng_data),
    .fifo_start_index  (d_fifo_start),
    .fifo_words        (d_fifo_words),
    .data_out          (d_data),
    .protocol          (d_protocol),
    .proto_reserved    (d_proto_reserved),
    .fcs_append        (d_fcs_append),
    .fcs_store         (d_fcs_store),
    .short_check       (d_short_check),
    .len_check         (d_len_check),
    .len_limit         (d_len_limit),
    .pad_fill_next     (d_pad_fill)
  );

  // answers hold until the next request so engines may sample late
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_valid          <= 1'b0;
      cfg_fifo_start     <= 6'h00;
      cfg_fifo_words     <= 8'h00;
      cfg_data           <= 8'h00;
      cfg_protocol       <= 3'h0;
      cfg_proto_reserved <= 1'b0;
      cfg_fcs_append     <= 1'b0;
      cfg_fcs_store      <= 1'b0;
      cfg_short_check    <= 1'b0;
      cfg_len_check      <= 1'b0;
      cfg_len_limit      <= {`HCCD_LIMIT_W{1'b0}};
      cfg_pad_fill_count <= 8'h00;
    end else begin
      // one valid pulse for each request cycle
      cfg_valid <= eng_req;
      if (eng_req) begin
        cfg_fifo_start     <= d_fifo_start;
        cfg_fifo_words     <= d_fifo_words;
        cfg_data           <= d_data;
        cfg_protocol       <= d_protocol;
        cfg_proto_reserved <= d_proto_reserved;
        cfg_fcs_append     <= d_fcs_append;
        cfg_fcs_store      <= d_fcs_store;
        cfg_short_check    <= d_short_check;
        cfg_len_check      <= d_len_check;
        cfg_len_limit      <= d_len_limit;
        cfg_pad_fill_count <= d_pad_fill;
      end
    end
  end

endmodule

// ==== core/hccd_defs.vh ====
// constants for the hdlc channel configuration descriptor bank
`ifndef HCCD_DEFS_VH
`define HCCD_DEFS_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define HCCD_CFG_BASE      12'h000
`define HCCD_CFG_LAST      12'h0FC
`define HCCD_IRQ_STATUS    12'h100
`define HCCD_IRQ_CLEAR     12'h104
`define HCCD_IRQ_ENABLE    12'h108
`define HCCD_ADDR_W        12

// ----------------------------------------------------------------
// descriptor fields
// ----------------------------------------------------------------
`define HCCD_PAD_ADJ_BIT   31
`define HCCD_RSVD_HI_BIT   30
`define HCCD_LOC_MSB       29
`define HCCD_LOC_LSB       24
`define HCCD_INVERT_BIT    23
`define HCCD_RSVD_LO_BIT   22
`define HCCD_LEN_MSB       21
`define HCCD_LEN_LSB       16
`define HCCD_EOP_IRQ_BIT   15
`define HCCD_PROTO_MSB     14
`define HCCD_PROTO_LSB     12
`define HCCD_LSEL_MSB      11
`define HCCD_LSEL_LSB      10
`define HCCD_FCS_BIT       9
`define HCCD_SUMSK_BIT     8
`define HCCD_CFG_RESET     32'h0000_0000

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define HCCD_PROTO_TRANSP  3'h0
`define HCCD_PROTO_SS7     3'h1
`define HCCD_PROTO_FCS16   3'h2
`define HCCD_PROTO_FCS32   3'h3
`define HCCD_LSEL_NONE     2'h0
`define HCCD_LSEL_ONE      2'h1
`define HCCD_LSEL_TWO      2'h2
`define HCCD_DIR_RX        1'b0
`define HCCD_DIR_TX        1'b1

// ----------------------------------------------------------------
// sizes, interrupt bits and bus transfer types
// ----------------------------------------------------------------
`define HCCD_CHAN_W        5
`define HCCD_IDX_W         6
`define HCCD_NUM_WORDS     64
`define HCCD_LIMIT_W       12
`define HCCD_IRQ_W         2
`define HCCD_IRQ_EOP       0
`define HCCD_IRQ_SU_ERR    1
`define HCCD_HTRANS_NONSEQ 2'h2
`define HCCD_HTRANS_SEQ    2'h3

`endif

// ==== core/hccd_cfg_decode.v ====
// decodes one channel configuration word into the settings the engines use
`timescale 1ns/100ps
`include "hccd_defs.vh"
module hccd_cfg_decode (
  // descriptor and direction
  input  wire [31:0]              cfg_word,
  input  wire                     dir,
  // per-message inputs from the channel engine
  input  wire [`HCCD_LIMIT_W-1:0] length_limit_one,
  input  wire [`HCCD_LIMIT_W-1:0] length_limit_two,
  input  wire [7:0]               pad_fill_count,
  input  wire [7:0]               zero_insert_count,
  input  wire [7:0]               data_in,
  // decoded settings
  output wire [5:0]               fifo_start_index,
  output wire [7:0]               fifo_words,
  output wire [7:0]               data_out,
  output wire [2:0]               protocol,
  output wire                     proto_reserved,
  output wire                     fcs_append,
  output wire                     fcs_store,
  output wire                     short_check,
  output wire                     len_check,
  output wire [`HCCD_LIMIT_W-1:0] len_limit,
  output wire [7:0]               pad_fill_next
);

  wire [5:0] fifo_length_field;
  wire [1:0] length_limit_select;
  wire       no_fcs;
  wire       data_invert;
  wire       pad_count_adjust_enable;
  wire       hdlc_mode;

  assign fifo_start_index        = cfg_word[`HCCD_LOC_MSB:`HCCD_LOC_LSB];
  assign fifo_length_field       = cfg_word[`HCCD_LEN_MSB:`HCCD_LEN_LSB];
  assign data_invert             = cfg_word[`HCCD_INVERT_BIT];
  assign pad_count_adjust_enable = cfg_word[`HCCD_PAD_ADJ_BIT];
  assign protocol                = cfg_word[`HCCD_PROTO_MSB:`HCCD_PROTO_LSB];
  assign length_limit_select     = cfg_word[`HCCD_LSEL_MSB:`HCCD_LSEL_LSB];
  assign no_fcs                  = cfg_word[`HCCD_FCS_BIT];

  // allocation is 2 x (field + 1) words
  assign fifo_words = {1'b0, fifo_length_field, 1'b0} + 8'h02;

  assign data_out = data_invert ? ~data_in : data_in;

  // reserved codes 4-7 are flagged and get no framing
  assign proto_reserved = protocol[2];
  assign hdlc_mode      = ~protocol[2] && (protocol != `HCCD_PROTO_TRANSP);

  assign fcs_append  = (dir == `HCCD_DIR_TX) && hdlc_mode && ~no_fcs;
  assign fcs_store   = (dir == `HCCD_DIR_RX) && hdlc_mode && no_fcs;
  assign short_check = hdlc_mode && ~no_fcs;

  // limit applies to receive only; select 3 behaves as no check
  assign len_check = (dir == `HCCD_DIR_RX) &&
                     ((length_limit_select == `HCCD_LSEL_ONE) ||
                      (length_limit_select == `HCCD_LSEL_TWO));
  assign len_limit = ~len_check ? {`HCCD_LIMIT_W{1'b0}} :
                     (length_limit_select == `HCCD_LSEL_ONE) ? length_limit_one :
                     length_limit_two;

  // saturating reduction by the zero insertions seen
  assign pad_fill_next = ~pad_count_adjust_enable ? pad_fill_count :
                         (pad_fill_count > zero_insert_count) ?
                         (pad_fill_count - zero_insert_count) : 8'h00;

endmodule

// ==== tb/hccd_asserts.sv ====
// assertion checker for the channel configuration bank ports
`timescale 1ns/100ps
`include "hccd_defs.vh"
module hccd_asserts (
  // clock and reset
  input wire                     hclk,
  input wire                     hresetn,
  // bus
  input wire                     hwrite,
  // engine lookup
  input wire                     eng_req,
  input wire [7:0]               eng_data,
  input wire [7:0]               pad_fill_count,
  input wire [`HCCD_LIMIT_W-1:0] length_limit_one,
  input wire [`HCCD_LIMIT_W-1:0] length_limit_two,
  input wire                     cfg_valid,
  input wire [7:0]               cfg_fifo_words,
  input wire [7:0]               cfg_data,
  input wire [2:0]               cfg_protocol,
  input wire                     cfg_proto_reserved,
  input wire                     cfg_fcs_append,
  input wire                     cfg_fcs_store,
  input wire                     cfg_short_check,
  input wire                     cfg_len_check,
  input wire [`HCCD_LIMIT_W-1:0] cfg_len_limit,
  input wire [7:0]               cfg_pad_fill_count,
  // events and interrupt
  input wire                     padfill_done,
  input wire                     signal_unit_error_event,
  input wire                     irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // lookup answers and interrupt cause
  // ----------------------------------------------------------------
  valid_pulse_a: assert property (!eng_req |=> !cfg_valid) else $error("answer without request");
  fifo_size_a: assert property (cfg_valid |-> !cfg_fifo_words[0] && cfg_fifo_words >= 8'h02 && cfg_fifo_words <= 8'h80)
    else $error("fifo size not twice length plus one");
  proto_rsvd_a: assert property (cfg_valid |-> cfg_proto_reserved == cfg_protocol[2])
    else $error("reserved protocol flag wrong");
  fcs_excl_a: assert property (cfg_valid |-> !(cfg_fcs_append && cfg_fcs_store))
    else $error("fcs append and store together");
  short_off_a: assert property (cfg_valid && cfg_fcs_store |-> !cfg_short_check)
    else $error("short check while fcs passed through");
  append_short_a: assert property (cfg_valid && cfg_fcs_append |-> cfg_short_check)
    else $error("fcs appended without short check");
  data_pass_a: assert property (eng_req |=> cfg_data == $past(eng_data) || cfg_data == ~$past(eng_data))
    else $error("data neither passed nor inverted");
  pad_down_a: assert property (eng_req |=> cfg_pad_fill_count <= $past(pad_fill_count))
    else $error("pad count grew");
  len_off_a: assert property (cfg_valid && !cfg_len_check |-> cfg_len_limit == 12'h000)
    else $error("limit given without length check");
  len_pick_a: assert property (eng_req ##1 cfg_len_check |->
    cfg_len_limit == $past(length_limit_one) || cfg_len_limit == $past(length_limit_two))
    else $error("length limit not one of the two limits");
  irq_cause_a: assert property ($rose(irq) |-> $past(padfill_done) || $past(signal_unit_error_event) || $past(hwrite, 2))
    else $error("interrupt rose without cause");

  cover property (cfg_valid && cfg_len_check);
  cover property (cfg_valid && cfg_fcs_store);
  cover property ($rose(irq));
endmodule

bind hccd_top hccd_asserts u_hccd_asserts (
  .hclk(hclk), .hresetn(hresetn), .hwrite(hwrite), .eng_req(eng_req), .eng_data(eng_data),
  .pad_fill_count(pad_fill_count), .length_limit_one(length_limit_one), .length_limit_two(length_limit_two),
  .cfg_valid(cfg_valid), .cfg_fifo_words(cfg_fifo_words), .cfg_data(cfg_data), .cfg_protocol(cfg_protocol),
  .cfg_proto_reserved(cfg_proto_reserved), .cfg_fcs_append(cfg_fcs_append), .cfg_fcs_store(cfg_fcs_store),
  .cfg_short_check(cfg_short_check), .cfg_len_check(cfg_len_check), .cfg_len_limit(cfg_len_limit),
  .cfg_pad_fill_count(cfg_pad_fill_count), .padfill_done(padfill_done),
  .signal_unit_error_event(signal_unit_error_event), .irq(irq));

// ==== tb/tb.sv ====
// self-checking testbench for the channel configuration bank
`timescale 1ns/100ps
`include "hccd_defs.vh"
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  reg         hclk, hresetn, hsel, hwrite, eng_req, eng_dir, padfill_done, signal_unit_error_event;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [4:0]  eng_chan, padfill_chan, signal_unit_error_chan;
  reg  [11:0] length_limit_one, length_limit_two;
  reg  [7:0]  pad_fill_count, zero_insert_count, eng_data;
  wire        hready, hreadyout, hresp, cfg_valid, cfg_proto_reserved, cfg_fcs_append;
  wire        cfg_fcs_store, cfg_short_check, cfg_len_check, irq;
  wire [31:0] hrdata;
  wire [11:0] cfg_len_limit;
  wire [7:0]  cfg_fifo_words, cfg_data, cfg_pad_fill_count;
  wire [5:0]  cfg_fifo_start;
  wire [2:0]  cfg_protocol;
  integer     n_fail, checks_done;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  hccd_top u_hccd_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .eng_req(eng_req), .eng_dir(eng_dir), .eng_chan(eng_chan), .length_limit_one(length_limit_one),
    .length_limit_two(length_limit_two), .pad_fill_count(pad_fill_count), .zero_insert_count(zero_insert_count),
    .eng_data(eng_data), .cfg_valid(cfg_valid), .cfg_fifo_start(cfg_fifo_start), .cfg_fifo_words(cfg_fifo_words),
    .cfg_data(cfg_data), .cfg_protocol(cfg_protocol), .cfg_proto_reserved(cfg_proto_reserved),
    .cfg_fcs_append(cfg_fcs_append), .cfg_fcs_store(cfg_fcs_store), .cfg_short_check(cfg_short_check),
    .cfg_len_check(cfg_len_check), .cfg_len_limit(cfg_len_limit), .cfg_pad_fill_count(cfg_pad_fill_count),
    .padfill_done(padfill_done), .padfill_chan(padfill_chan), .signal_unit_error_event(signal_unit_error_event),
    .signal_unit_error_chan(signal_unit_error_chan), .irq(irq));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // bounded wait for ready; a hang ends the run
  task wait_rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
        n = n + 1;
        if (n > 50) begin
          n_fail = n_fail + 1;
          stop_test;
        end
        @(posedge hclk);
      end
    end
  endtask

  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `HCCD_HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
    end
  endtask

  task rchk(input [95:0] nm, input [31:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
      chk("resp", 32'h0, hresp);
    end
  endtask

  task look(input dir, input [4:0] ch);
    begin
      eng_req <= 1'b1;
      eng_dir <= dir;
      eng_chan <= ch;
      @(posedge hclk);
      eng_req <= 1'b0;
      @(posedge hclk);
      chk("valid", 32'h1, cfg_valid);
    end
  endtask

  // k selects the signal-unit error event, else end of padfill
  task ev(input k, input [4:0] c);
    begin
      if (k) begin
        signal_unit_error_event <= 1'b1;
        signal_unit_error_chan <= c;
      end else begin
        padfill_done <= 1'b1;
        padfill_chan <= c;
      end
      @(posedge hclk);
      padfill_done <= 1'b0;
      signal_unit_error_event <= 1'b0;
      @(posedge hclk);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_map;
    begin
      rchk("rx0", 32'h0, 32'h0);
      rchk("enable", 32'h108, 32'h0);
      bus(1'b1, 32'h94, 32'h3F3F3000);
      bus(1'b1, 32'h14, 32'h00002000);
      bus(1'b1, 32'hFC, 32'hFFFFFFFF);
      bus(1'b1, 32'h200, 32'h00001234);
      rchk("tx5", 32'h94, 32'h3F3F3000);
      rchk("rx5", 32'h14, 32'h00002000);
      rchk("tx31", 32'hFC, 32'hFFFFFFFF);
      rchk("unmapped", 32'h200, 32'h0);
      look(1'b1, 5'h05);
      chk("start", 32'h3F, cfg_fifo_start);
      chk("words", 32'h80, cfg_fifo_words);
      chk("proto", 32'h3, cfg_protocol);
      look(1'b0, 5'h05);
      chk("start", 32'h0, cfg_fifo_start);
      chk("words", 32'h2, cfg_fifo_words);
      chk("store", 32'h0, cfg_fcs_store);
    end
  endtask

  task t_data;
    begin
      eng_data <= 8'h5A;
      pad_fill_count <= 8'h0A;
      zero_insert_count <= 8'h03;
      bus(1'b1, 32'h0, 32'h0);
      look(1'b0, 5'h00);
      chk("data", 32'h5A, cfg_data);
      chk("pad", 32'h0A, cfg_pad_fill_count);
      bus(1'b1, 32'h0, 32'h80800000);
      look(1'b0, 5'h00);
      chk("data", 32'hA5, cfg_data);
      chk("pad", 32'h07, cfg_pad_fill_count);
      zero_insert_count <= 8'h14;
      look(1'b0, 5'h00);
      chk("pad", 32'h00, cfg_pad_fill_count);
    end
  endtask

  task t_proto;
    integer p;
    begin
      for (p = 0; p < 8; p = p + 1) begin
        bus(1'b1, 32'h84, p << 12);
        look(1'b1, 5'h01);
        chk("proto", p, cfg_protocol);
        chk("rsvd", p > 3, cfg_proto_reserved);
        chk("append", p > 0 && p < 4, cfg_fcs_append);
        chk("short", p > 0 && p < 4, cfg_short_check);
      end
      bus(1'b1, 32'h84, 32'h00002200);
      look(1'b1, 5'h01);
      chk("append", 32'h0, cfg_fcs_append);
      chk("short", 32'h0, cfg_short_check);
      bus(1'b1, 32'h4, 32'h00002200);
      look(1'b0, 5'h01);
      chk("store", 32'h1, cfg_fcs_store);
      chk("short", 32'h0, cfg_short_check);
    end
  endtask

  task t_len;
    integer s;
    begin
      length_limit_one <= 12'h123;
      length_limit_two <= 12'hABC;
      for (s = 0; s < 4; s = s + 1) begin
        bus(1'b1, 32'h0, s << 10);
        look(1'b0, 5'h00);
        chk("lencheck", s == 1 || s == 2, cfg_len_check);
        chk("limit", s == 1 ? 32'h123 : s == 2 ? 32'hABC : 32'h0, cfg_len_limit);
      end
    end
  endtask

  task t_irq;
    begin
      bus(1'b1, 32'h88, 32'h00008000);
      bus(1'b1, 32'h108, 32'h3);
      ev(1'b0, 5'h02);
      chk("irq", 32'h1, irq);
      bus(1'b1, 32'h100, 32'h0);
      rchk("status", 32'h100, 32'h1);
      bus(1'b1, 32'h104, 32'h1);
      rchk("status", 32'h100, 32'h0);
      chk("irq", 32'h0, irq);
      rchk("clear", 32'h104, 32'h0);
      ev(1'b0, 5'h03);
      rchk("status", 32'h100, 32'h0);
      bus(1'b1, 32'h10, 32'h00001000);
      ev(1'b1, 5'h04);
      chk("irq", 32'h1, irq);
      rchk("status", 32'h100, 32'h2);
      bus(1'b1, 32'h104, 32'h2);
      bus(1'b1, 32'h10, 32'h00001100);
      ev(1'b1, 5'h04);
      rchk("status", 32'h100, 32'h0);
      bus(1'b1, 32'h10, 32'h00001000);
      bus(1'b1, 32'h108, 32'h1);
      ev(1'b1, 5'h04);
      chk("irq", 32'h0, irq);
      rchk("status", 32'h100, 32'h2);
    end
  endtask

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, eng_req, eng_dir, padfill_done, signal_unit_error_event} = '0;
    {haddr, hwdata, htrans, eng_chan, padfill_chan, signal_unit_error_chan} = '0;
    {length_limit_one, length_limit_two, pad_fill_count, zero_insert_count, eng_data} = '0;
    hsize = 3'h2;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_map;
    t_data;
    t_proto;
    t_len;
    t_irq;
    stop_test;
  end
endmodule
